/* logic/bitblt_defines.vh */
/*
 * Constants of the block transfer engine: register indices, control
 * field positions, function codes, reset values and state codes.
 * Assumes it is included by bare name from the design files.
 */
`ifndef BITBLT_DEFINES_VH
`define BITBLT_DEFINES_VH

// Register indices on the plain register port.
`define REG_SRC_BASE 4'h0
`define REG_DST_BASE 4'h1
`define REG_SHIFT 4'h2
`define REG_HEIGHT 4'h3
`define REG_MASK_FIRST 4'h4
`define REG_MASK_SECOND 4'h5
`define REG_SRC_WARP 4'h6
`define REG_DST_WARP 4'h7
`define REG_WIDTH 4'h8
`define REG_CONTROL 4'h9
`define REG_STATUS 4'ha
`define REG_ORIGIN 4'hb
`define REG_COORD 4'hc
`define REG_PLANE_WARP 4'hd
`define REG_PIXEL_ADDR 4'he

// Control register fields.
`define CTL_START 0
`define CTL_FUNC_LO 1
`define CTL_FUNC_HI 3
`define CTL_INVERT 4
`define CTL_DESCEND 5

// Status register fields.
`define STS_BUSY 0
`define STS_DONE 1
`define STS_EXT_BUSY 2

// Function codes.
`define FN_AND 3'h0
`define FN_OR 3'h1
`define FN_XOR 3'h2
`define FN_COPY 3'h3
`define FN_FAST_OR 3'h4
`define FN_EXTERNAL 3'h5

// Reset values.
`define RST_WORD 32'h00000000
`define RST_MASK 16'hffff

// Memory word geometry: one word is two bytes.
`define WORD_BYTES 24'h000002

// Engine states.
`define ST_IDLE 3'h0
`define ST_LINE 3'h1
`define ST_RD_SRC 3'h2
`define ST_RD_DST 3'h3
`define ST_WRITE 3'h4
`define ST_EXT 3'h5

`endif

/* logic/bitblt_aligner.v */
/*
 * Source aligner: joins the previous and current source words of a scan
 * line and shifts them so the first source pixel meets the first
 * destination pixel. Assumes shift values 0 to 15 and 16-bit words.
 */
`timescale 1ns/1ps
`default_nettype none

module bitblt_aligner (
    input wire [15:0] prev_word,
    input wire [15:0] cur_word,
    input wire [3:0] shift,
    input wire descend,
    output wire [15:0] aligned
);
    wire [31:0] joined;
    wire [31:0] shifted;

    // Bit 0 is the first pixel, so shifting toward higher bit numbers moves pixels right.
    assign joined = descend ? {prev_word, cur_word} : {cur_word, prev_word};
    assign shifted = joined << shift;
    assign aligned = shifted[31:16];
endmodule // bitblt_aligner

`default_nettype wire

/* logic/bitblt_combiner.v */
/*
 * Raster operation on one word: combines aligned source and destination
 * with the selected function, then lets only mask-one bits change.
 * Assumes function codes from the shared constants header.
 */
`timescale 1ns/1ps
`default_nettype none
`include "bitblt_defines.vh"

module bitblt_combiner (
    input wire [15:0] src,
    input wire [15:0] dst,
    input wire [15:0] mask,
    input wire [2:0] func,
    input wire invert,
    output reg [15:0] result
);
    reg [15:0] s;
    reg [15:0] op;

    // Inverted source is refused for the fast OR; masked bits keep the destination.
    always @* begin
        s = (invert && func != `FN_FAST_OR) ? ~src : src;
        case (func)
            `FN_AND: op = s & dst;
            `FN_XOR: op = s ^ dst;
            `FN_COPY: op = s;
            default: op = s | dst;
        endcase
        result = (op & mask) | (dst & ~mask);
    end
endmodule // bitblt_combiner

`default_nettype wire

/* logic/bitblt_engine.v */
/*
 * Bit-aligned block transfer engine. Reads a source rectangle word by
 * word, aligns it, combines it with the destination and writes it back,
 * running the word and scan-line loops itself.
 * Assumes a same-clock word memory that answers each request with a
 * one-cycle acknowledge, and a same-clock register master.
 */
// Function
// - Pixel address is origin plus y*warp plus x.
// - Origin top left; right, down increase coordinates.
// - Warp is vertical bit distance; x steps one.
// - Word bit zero is first displayed pixel.
// - Shift source to align first pixels.
// - Combine with selected function, write destination.
// - Every memory access is an aligned word.
// - Edge masks protect bits outside rectangle.
// - Zero mask bit leaves destination unchanged.
// - Same masks on every scan line.
// - Word loop per word, line loop per height.
// - Software sets up; engine runs loops alone.
// - Both horizontal and both vertical directions supported.
// - Setup supplies bases, shift, height, masks, warps, width.
// - Ascending order default; descending reverses it.
// - One operation drives external unit, five internal.
// - Warp sign sets vertical, option sets horizontal.
// - AND, OR, XOR, copy, true/inverted, fast OR.
// - Width counts source words; masks source relative.
`timescale 1ns/1ps
`default_nettype none
`include "bitblt_defines.vh"

module bitblt_engine (
    input wire clock,
    input wire nrst,
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_ff,
    output reg mem_req_ff,
    output reg mem_we_ff,
    output reg [23:0] mem_addr_ff,
    output reg [15:0] mem_wdata_ff,
    input wire [15:0] mem_rdata,
    input wire mem_ack,
    output reg done_ff,
    output reg ext_start_ff,
    input wire ext_done
);
    // Setup registers.
    reg [23:0] src_base_ff;
    reg [23:0] dst_base_ff;
    reg [3:0] shift_ff;
    reg [15:0] height_ff;
    reg [15:0] mask_first_ff;
    reg [15:0] mask_second_ff;
    reg [31:0] src_warp_ff;
    reg [31:0] dst_warp_ff;
    reg [15:0] width_ff;
    reg [2:0] func_ff;
    reg invert_ff;
    reg descend_ff;
    // Pixel address helper registers.
    reg [31:0] origin_ff;
    reg [15:0] coord_x_ff;
    reg [15:0] coord_y_ff;
    reg [31:0] plane_warp_ff;
    reg [31:0] pixel_addr_ff;
    // Loop state.
    reg [2:0] state_ff;
    reg [23:0] src_line_ff;
    reg [23:0] dst_line_ff;
    reg [23:0] src_ptr_ff;
    reg [23:0] dst_ptr_ff;
    reg [15:0] lines_left_ff;
    reg [15:0] words_left_ff;
    reg [15:0] prev_src_ff;
    reg [15:0] cur_src_ff;
    reg first_word_ff;
    reg done_flag_ff;
    reg ext_sync1_ff;
    reg ext_sync2_ff;

    // Combinational helpers shared by the sequencer and the datapath.
    wire start_req;
    wire fast_or;
    wire eff_descend;
    wire [23:0] word_step;
    wire last_word;
    wire last_line;
    wire [15:0] aligned;
    wire [15:0] word_mask;
    wire [15:0] result;
    wire [31:0] pixel_calc;

    // A start is taken only while idle; control writes during a run are ignored.
    assign start_req = reg_wr && reg_addr == `REG_CONTROL && reg_wdata[`CTL_START] && state_ff == `ST_IDLE;
    // Fast OR always runs ascending with true source.
    assign fast_or = func_ff == `FN_FAST_OR;
    assign eff_descend = descend_ff && !fast_or;
    assign word_step = eff_descend ? (24'h000000 - `WORD_BYTES) : `WORD_BYTES;
    // The last word and the last line are flagged while one count remains.
    assign last_word = words_left_ff == 16'h0001;
    assign last_line = lines_left_ff == 16'h0001;
    // First word takes the first mask, last word the second, a lone word both.
    assign word_mask = (first_word_ff ? mask_first_ff : `RST_MASK)
                       & (last_word ? mask_second_ff : `RST_MASK);
    assign pixel_calc = origin_ff + coord_y_ff * plane_warp_ff + {16'h0000, coord_x_ff};

    // Source alignment ahead of the raster operation.
    bitblt_aligner u_aligner (
        .prev_word(prev_src_ff),
        .cur_word(cur_src_ff),
        .shift(shift_ff),
        .descend(eff_descend),
        .aligned(aligned)
    );

    // Function and masking of one destination word.
    bitblt_combiner u_combiner (
        .src(aligned),
        .dst(mem_rdata),
        .mask(word_mask),
        .func(func_ff),
        .invert(invert_ff),
        .result(result)
    );

    // Two flip-flops bring the external unit's completion into this clock.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ext_sync1_ff <= 1'b0;
            ext_sync2_ff <= 1'b0;
        end else begin
            ext_sync1_ff <= ext_done;
            ext_sync2_ff <= ext_sync1_ff;
        end
    end

    // Setup registers written by software; ignored while a transfer runs.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            src_base_ff <= 24'h000000;
            dst_base_ff <= 24'h000000;
            shift_ff <= 4'h0;
            height_ff <= 16'h0000;
            mask_first_ff <= `RST_MASK;
            mask_second_ff <= `RST_MASK;
            src_warp_ff <= `RST_WORD;
            dst_warp_ff <= `RST_WORD;
            width_ff <= 16'h0000;
            func_ff <= `FN_AND;
            invert_ff <= 1'b0;
            descend_ff <= 1'b0;
            origin_ff <= `RST_WORD;
            coord_x_ff <= 16'h0000;
            coord_y_ff <= 16'h0000;
            plane_warp_ff <= `RST_WORD;
        end else if (reg_wr && state_ff == `ST_IDLE) begin
            case (reg_addr)
                `REG_SRC_BASE: src_base_ff <= reg_wdata[23:0];
                `REG_DST_BASE: dst_base_ff <= reg_wdata[23:0];
                `REG_SHIFT: shift_ff <= reg_wdata[3:0];
                `REG_HEIGHT: height_ff <= reg_wdata[15:0];
                `REG_MASK_FIRST: mask_first_ff <= reg_wdata[15:0];
                `REG_MASK_SECOND: mask_second_ff <= reg_wdata[15:0];
                `REG_SRC_WARP: src_warp_ff <= reg_wdata;
                `REG_DST_WARP: dst_warp_ff <= reg_wdata;
                `REG_WIDTH: width_ff <= reg_wdata[15:0];
                `REG_CONTROL: begin
                    func_ff <= reg_wdata[`CTL_FUNC_HI:`CTL_FUNC_LO];
                    invert_ff <= reg_wdata[`CTL_INVERT];
                    descend_ff <= reg_wdata[`CTL_DESCEND];
                end
                `REG_ORIGIN: origin_ff <= reg_wdata;
                `REG_COORD: begin
                    coord_x_ff <= reg_wdata[15:0];
                    coord_y_ff <= reg_wdata[31:16];
                end
                `REG_PLANE_WARP: plane_warp_ff <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Pixel address follows the origin, warp and coordinates each cycle.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pixel_addr_ff <= `RST_WORD;
        end else begin
            pixel_addr_ff <= pixel_calc;
        end
    end

    // Read data appear the cycle after the read strobe; unmapped reads give zero.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            reg_rdata_ff <= `RST_WORD;
        end else if (reg_rd) begin
            case (reg_addr)
                `REG_SRC_BASE: reg_rdata_ff <= {8'h00, src_base_ff};
                `REG_DST_BASE: reg_rdata_ff <= {8'h00, dst_base_ff};
                `REG_SHIFT: reg_rdata_ff <= {28'h0000000, shift_ff};
                `REG_HEIGHT: reg_rdata_ff <= {16'h0000, height_ff};
                `REG_MASK_FIRST: reg_rdata_ff <= {16'h0000, mask_first_ff};
                `REG_MASK_SECOND: reg_rdata_ff <= {16'h0000, mask_second_ff};
                `REG_SRC_WARP: reg_rdata_ff <= src_warp_ff;
                `REG_DST_WARP: reg_rdata_ff <= dst_warp_ff;
                `REG_WIDTH: reg_rdata_ff <= {16'h0000, width_ff};
                `REG_CONTROL: reg_rdata_ff <= {26'h0000000, descend_ff, invert_ff, func_ff, 1'b0};
                `REG_STATUS: reg_rdata_ff <= {29'h00000000, state_ff == `ST_EXT, done_flag_ff,
                                              state_ff != `ST_IDLE};
                `REG_ORIGIN: reg_rdata_ff <= origin_ff;
                `REG_COORD: reg_rdata_ff <= {coord_y_ff, coord_x_ff};
                `REG_PLANE_WARP: reg_rdata_ff <= plane_warp_ff;
                `REG_PIXEL_ADDR: reg_rdata_ff <= pixel_addr_ff;
                default: reg_rdata_ff <= `RST_WORD;
            endcase
        end else begin
            reg_rdata_ff <= `RST_WORD;
        end
    end

    // Sticky completion flag: completion wins over a software clear in the same cycle.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            done_flag_ff <= 1'b0;
        end else if (done_ff) begin
            done_flag_ff <= 1'b1;
        end else if (start_req || (reg_wr && reg_addr == `REG_STATUS && reg_wdata[`STS_DONE])) begin
            done_flag_ff <= 1'b0;
        end
    end

    // Transfer sequencer: source read, destination read, write, per word and per line.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_ff <= `ST_IDLE;
            src_line_ff <= 24'h000000;
            dst_line_ff <= 24'h000000;
            src_ptr_ff <= 24'h000000;
            dst_ptr_ff <= 24'h000000;
            lines_left_ff <= 16'h0000;
            words_left_ff <= 16'h0000;
            prev_src_ff <= 16'h0000;
            cur_src_ff <= 16'h0000;
            first_word_ff <= 1'b0;
            mem_req_ff <= 1'b0;
            mem_we_ff <= 1'b0;
            mem_addr_ff <= 24'h000000;
            mem_wdata_ff <= 16'h0000;
            done_ff <= 1'b0;
            ext_start_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            ext_start_ff <= 1'b0;
            case (state_ff)
                `ST_IDLE: begin
                    // Zero height or width finishes at once with no memory traffic.
                    if (start_req) begin
                        if (reg_wdata[`CTL_FUNC_HI:`CTL_FUNC_LO] == `FN_EXTERNAL) begin
                            ext_start_ff <= 1'b1;
                            state_ff <= `ST_EXT;
                        end else if (height_ff == 16'h0000 || width_ff == 16'h0000) begin
                            done_ff <= 1'b1;
                        end else begin
                            src_line_ff <= src_base_ff;
                            dst_line_ff <= dst_base_ff;
                            lines_left_ff <= height_ff;
                            state_ff <= `ST_LINE;
                        end
                    end
                end
                `ST_LINE: begin
                    // Reload the word loop and ask for the first source word.
                    src_ptr_ff <= src_line_ff;
                    dst_ptr_ff <= dst_line_ff;
                    words_left_ff <= width_ff;
                    prev_src_ff <= 16'h0000;
                    first_word_ff <= 1'b1;
                    mem_req_ff <= 1'b1;
                    mem_we_ff <= 1'b0;
                    mem_addr_ff <= {src_line_ff[23:1], 1'b0};
                    state_ff <= `ST_RD_SRC;
                end
                `ST_RD_SRC: begin
                    if (mem_ack) begin
                        cur_src_ff <= mem_rdata;
                        mem_addr_ff <= {dst_ptr_ff[23:1], 1'b0};
                        state_ff <= `ST_RD_DST;
                    end
                end
                `ST_RD_DST: begin
                    if (mem_ack) begin
                        mem_we_ff <= 1'b1;
                        mem_wdata_ff <= result;
                        state_ff <= `ST_WRITE;
                    end
                end
                `ST_WRITE: begin
                    if (mem_ack) begin
                        // Step both pointers; close the line or fetch the next source word.
                        prev_src_ff <= cur_src_ff;
                        first_word_ff <= 1'b0;
                        mem_we_ff <= 1'b0;
                        src_ptr_ff <= src_ptr_ff + word_step;
                        dst_ptr_ff <= dst_ptr_ff + word_step;
                        words_left_ff <= words_left_ff - 16'h0001;
                        if (!last_word) begin
                            mem_addr_ff <= {src_ptr_ff[23:1], 1'b0} + word_step;
                            state_ff <= `ST_RD_SRC;
                        end else begin
                            // Warp sign chooses the vertical direction.
                            src_line_ff <= src_line_ff + src_warp_ff[23:0];
                            dst_line_ff <= dst_line_ff + dst_warp_ff[23:0];
                            lines_left_ff <= lines_left_ff - 16'h0001;
                            mem_req_ff <= 1'b0;
                            if (last_line) begin
                                done_ff <= 1'b1;
                                state_ff <= `ST_IDLE;
                            end else begin
                                state_ff <= `ST_LINE;
                            end
                        end
                    end
                end
                `ST_EXT: begin
                    // The external unit runs alone until its synchronised done arrives.
                    if (ext_sync2_ff) begin
                        done_ff <= 1'b1;
                        state_ff <= `ST_IDLE;
                    end
                end
                default: state_ff <= `ST_IDLE;
            endcase
        end
    end
endmodule // bitblt_engine

`default_nettype wire

/* verif/bitblt_engine_asserts.sv */
/* Checker of the engine's memory and register port timing.
   Assumes it is bound to the engine top module, one clock. */
`timescale 1ns/1ps
`default_nettype none

module bitblt_engine_asserts (
    input wire logic clock,
    input wire logic nrst,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata_ff,
    input wire logic mem_req_ff,
    input wire logic mem_we_ff,
    input wire logic [23:0] mem_addr_ff,
    input wire logic [15:0] mem_wdata_ff,
    input wire logic mem_ack,
    input wire logic done_ff,
    input wire logic ext_start_ff
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    // Memory requests are whole words and stand until acknowledged.
    a_word_aligned: assert property (mem_req_ff |-> !mem_addr_ff[0]) else $error("Odd memory address.");
    a_we_in_req: assert property (mem_we_ff |-> mem_req_ff) else $error("Write flag without request.");
    a_req_held: assert property (mem_req_ff && !mem_ack |=> mem_req_ff && $stable(mem_addr_ff)
        && $stable(mem_we_ff)) else $error("Request dropped before acknowledge.");
    a_wdata_held: assert property (mem_req_ff && mem_we_ff && !mem_ack |=> $stable(mem_wdata_ff))
        else $error("Write word changed while waiting.");
    a_read_follows: assert property (mem_req_ff && mem_we_ff && mem_ack |=> !mem_we_ff)
        else $error("Two writes in a row.");
    // Completion and external start are lone pulses with the memory port quiet.
    a_done_pulse: assert property (done_ff |=> !done_ff) else $error("Done longer than a cycle.");
    a_done_quiet: assert property (done_ff |-> !mem_req_ff) else $error("Access during done.");
    a_ext_pulse: assert property (ext_start_ff |=> !ext_start_ff) else $error("Long external start.");
    a_ext_no_mem: assert property (ext_start_ff |-> !mem_req_ff) else $error("Access at external start.");
    // Read data stand only in the cycle after a read strobe.
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_ff == 32'h0) else $error("Stray read data.");

    // Main scenarios.
    c_done: cover property (done_ff);
    c_ext: cover property (ext_start_ff);
    c_slow: cover property (mem_req_ff && !mem_ack ##1 mem_ack);
    c_write: cover property (mem_we_ff && mem_ack);
endmodule // bitblt_engine_asserts

bind bitblt_engine bitblt_engine_asserts chk (.clock(clock), .nrst(nrst), .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff), .mem_req_ff(mem_req_ff), .mem_we_ff(mem_we_ff), .mem_addr_ff(mem_addr_ff),
    .mem_wdata_ff(mem_wdata_ff), .mem_ack(mem_ack), .done_ff(done_ff), .ext_start_ff(ext_start_ff));
`default_nettype wire

/* verif/frame_memory.sv */
/* Word memory model of 64 sixteen-bit words with a set answer delay.
   Assumes requests held until the acknowledge edge, one clock. */
`timescale 1ns/1ps
`default_nettype none

module frame_memory (
    input wire logic clock,
    input wire logic nrst,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [23:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    input wire logic [3:0] delay,
    output logic [15:0] rdata_ff,
    output logic ack_ff
);
    logic [15:0] words_ff [0:63];
    logic [3:0] cnt_ff;
    logic [5:0] idx;

    // Byte address bit 0 is ignored, so every access is a whole word.
    assign idx = mem_addr[6:1];

    // One-cycle acknowledge after the delay; released data show the inverse.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ack_ff <= 1'b0;
            cnt_ff <= 4'h0;
            rdata_ff <= 16'h0;
        end else if (ack_ff) begin
            ack_ff <= 1'b0;
            cnt_ff <= 4'h0;
            rdata_ff <= ~rdata_ff;
            if (mem_we) begin
                words_ff[idx] <= mem_wdata;
            end
        end else if (mem_req && cnt_ff >= delay) begin
            ack_ff <= 1'b1;
            rdata_ff <= words_ff[idx];
        end else if (mem_req) begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end
endmodule // frame_memory
`default_nettype wire

/* verif/bitblt_engine_tb.sv */
/* Self-checking bench of the block transfer engine with a memory model.
   Assumes the register map and function codes of the shared header. */
`timescale 1ns/1ps
`default_nettype none
`include "bitblt_defines.vh"

module bitblt_engine_tb;
    logic clock, nrst, reg_wr, reg_rd, mem_req_ff, mem_we_ff, mem_ack, done_ff, ext_start_ff, ext_done;
    logic [3:0] reg_addr, delay;
    logic [31:0] reg_wdata, reg_rdata_ff;
    logic [23:0] mem_addr_ff;
    logic [15:0] mem_wdata_ff, mem_rdata;
    logic [15:0] exp_words [0:63];
    int num_errors, compares, acc_count = 0, n0, k;

    bitblt_engine uut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .mem_req_ff(mem_req_ff),
        .mem_we_ff(mem_we_ff), .mem_addr_ff(mem_addr_ff), .mem_wdata_ff(mem_wdata_ff), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack), .done_ff(done_ff), .ext_start_ff(ext_start_ff), .ext_done(ext_done));
    frame_memory u_mem (.clock(clock), .nrst(nrst), .mem_req(mem_req_ff), .mem_we(mem_we_ff),
        .mem_addr(mem_addr_ff), .mem_wdata(mem_wdata_ff), .delay(delay), .rdata_ff(mem_rdata), .ack_ff(mem_ack));

    // Clock and a count of completed memory accesses.
    always #12.5 clock = ~clock;
    always @(posedge clock) if (mem_req_ff === 1'b1 && mem_ack === 1'b1) acc_count <= acc_count + 1;

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task rd_check(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 check("register", reg_rdata_ff, exp);
    endtask

    // Waits for the completion pulse, then checks the sticky flag and its clearing.
    task wait_done;
        #1; // A zero-size transfer pulses done at its start edge already.
        for (k = 0; k < 3000 && done_ff !== 1'b1; k++) @(posedge clock) #1;
        check("done", done_ff, 1'b1);
        repeat (4) @(posedge clock);
        rd_check(`REG_STATUS, 32'h2);
        wr(`REG_STATUS, 32'h2);
        rd_check(`REG_STATUS, 32'h0);
    endtask

    // Preloads memory, predicts the destination, runs one transfer and compares all words.
    task run_blt(input logic [2:0] f, input logic inv, input logic desc, input logic [3:0] s,
        input logic [31:0] w, input logic [31:0] h, input logic [31:0] sb, input logic [31:0] db,
        input logic [31:0] sw, input logic [31:0] dw, input logic [15:0] m1, input logic [15:0] m2,
        input logic [3:0] dl);
        int l, i;
        logic ed, ei;
        logic [23:0] sa, da, st, sl, dln;
        logic [15:0] prev, cur, sv, dv, r, mk;
        logic [31:0] cat;
        ed = desc && f != `FN_FAST_OR;
        ei = inv && f != `FN_FAST_OR;
        st = ed ? 24'hfffffe : `WORD_BYTES;
        for (i = 0; i < 64; i++) begin
            u_mem.words_ff[i] = 16'(i * 11101) ^ {12'h9c3, s};
            exp_words[i] = u_mem.words_ff[i];
        end
        sl = sb[23:0];
        dln = db[23:0];
        for (l = 0; l < h; l++) begin
            // Each line starts one warp after the start of the line before.
            sa = sl;
            da = dln;
            prev = 16'h0;
            for (i = 0; i < w; i++) begin
                cur = exp_words[sa[6:1]];
                cat = ed ? {prev, cur} << s : {cur, prev} << s;
                prev = cur;
                sv = ei ? ~cat[31:16] : cat[31:16];
                dv = exp_words[da[6:1]];
                case (f)
                    `FN_AND: r = sv & dv;
                    `FN_XOR: r = sv ^ dv;
                    `FN_COPY: r = sv;
                    default: r = sv | dv;
                endcase
                mk = (i == 0 ? m1 : 16'hffff) & (i == w - 1 ? m2 : 16'hffff);
                exp_words[da[6:1]] = (r & mk) | (dv & ~mk);
                sa = sa + st;
                da = da + st;
            end
            sl = sl + sw[23:0];
            dln = dln + dw[23:0];
        end
        delay <= dl;
        wr(`REG_SRC_BASE, sb);
        wr(`REG_DST_BASE, db);
        wr(`REG_SHIFT, {28'h0, s});
        wr(`REG_HEIGHT, h);
        wr(`REG_MASK_FIRST, {16'h0, m1});
        wr(`REG_MASK_SECOND, {16'h0, m2});
        wr(`REG_SRC_WARP, sw);
        wr(`REG_DST_WARP, dw);
        wr(`REG_WIDTH, w);
        n0 = acc_count;
        wr(`REG_CONTROL, {26'h0, desc, inv, f, 1'b1});
        if (w != 0 && h != 0) wr(`REG_SHIFT, 32'hf);
        wait_done;
        check("accesses", 32'(acc_count - n0), 3 * w * h);
        for (i = 0; i < 64; i++) check("word", u_mem.words_ff[i], exp_words[i]);
        rd_check(`REG_SHIFT, {28'h0, s});
    endtask

    task complete_run;
        $display("checks %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        #(25 * 40000);
        num_errors++;
        complete_run;
    end

    initial begin
        {clock, reg_wr, reg_rd, ext_done, reg_addr, delay, reg_wdata} = '0;
        nrst = 1'b0;
        num_errors = 0;
        compares = 0;
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        rd_check(`REG_STATUS, 32'h0);
        rd_check(4'hf, 32'h0);
        // Pixel address from origin, warp and coordinates; the result is read-only.
        wr(`REG_ORIGIN, 32'h100);
        wr(`REG_PLANE_WARP, 32'h20);
        wr(`REG_COORD, 32'h00030005);
        rd_check(`REG_PIXEL_ADDR, 32'h165);
        wr(`REG_COORD, 32'h00060013);
        wr(`REG_PIXEL_ADDR, 32'h0);
        rd_check(`REG_PIXEL_ADDR, 32'h1d3);
        // AND, OR, XOR and copy with true and inverted source, back to back; then overlapping descending copy, upward warp, fast OR, zero width.
        for (int f = 0; f < 4; f++)
            for (int v = 0; v < 2; v++)
                run_blt(3'(f), v[0], 1'b0, 4'h3, 2, 2, 0, 32'h40, 4, 4, 16'hfff0, 16'h00ff, 0);
        run_blt(`FN_COPY, 1'b0, 1'b1, 4'h5, 3, 2, 6, 32'h08, 32'h10, 32'h10, 16'h7fff, 16'hff00, 1);
        run_blt(`FN_COPY, 1'b1, 1'b0, 4'h0, 1, 2, 32'h10, 32'h50, 32'hffffffee, 32'hffffffee,
            16'h0ff0, 16'h3ffc, 3);
        run_blt(`FN_FAST_OR, 1'b1, 1'b1, 4'h9, 2, 1, 32'h20, 32'h60, 0, 0, 16'hffff, 16'hffff, 2);
        run_blt(`FN_COPY, 1'b0, 1'b0, 4'h1, 0, 3, 0, 32'h40, 0, 0, 16'hffff, 16'hffff, 0);
        // External unit: start pulse, no memory traffic, completion after its done.
        n0 = acc_count;
        wr(`REG_CONTROL, {26'h0, 2'b00, `FN_EXTERNAL, 1'b1});
        #1 check("ext start", ext_start_ff, 1'b1);
        repeat (3) @(posedge clock);
        ext_done <= 1'b1;
        wait_done;
        ext_done <= 1'b0;
        check("ext accesses", 32'(acc_count - n0), 32'h0);
        complete_run;
    end
endmodule // bitblt_engine_tb
`default_nettype wire
